// >>> adc_compute_pkg.sv
package adc_compute_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_RUN_CONTROL = 10'h3f0;
	localparam logic [9:0] IDX_COMPUTE_CONTROL = 10'h3f5;
	localparam logic [9:0] IDX_ERROR_THRESHOLD_CONTROL = 10'h3f6;
	localparam logic [9:0] IDX_COMPUTE_STATUS = 10'h3f7;
	localparam logic [9:0] IDX_THRESHOLDS = 10'h3e0;
	localparam logic [9:0] IDX_SETPOINT_REPEAT = 10'h3e1;
	localparam logic [9:0] IDX_ACCUMULATOR = 10'h3e2;
	localparam logic [9:0] IDX_FILTER_PREVIOUS = 10'h3e3;
	localparam logic [9:0] IDX_ERROR_COUNT = 10'h3e4;
	localparam logic [7:0] COMPUTE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] ERROR_THRESHOLD_CONTROL_RESET = 8'h00;
	// compute_control fields
	localparam int PREV_SRC_BIT = 7;
	localparam int SHIFT_LSB = 4;
	localparam int ACCUM_CLEAR_BIT = 3;
	localparam int MODE_LSB = 0;
	// error_threshold_control fields
	localparam int ERR_SEL_LSB = 4;
	localparam int STOP_ON_THR_BIT = 3;
	localparam int THR_MODE_LSB = 0;
	// compute_status fields
	localparam int OVERFLOW_BIT = 7;
	localparam int ABOVE_BIT = 6;
	localparam int BELOW_BIT = 5;
	localparam int UPDATE_BIT = 4;
	// run_control fields
	localparam int GO_BIT = 0;
	localparam int CONTINUOUS_ENABLE_BIT = 1;
	localparam int DOUBLE_SAMPLE_ENABLE_BIT = 2;
	localparam int ACC_W = 18;
	localparam logic [2:0] STAT_IDLE = 3'h0;
	localparam logic [2:0] STAT_SUSPENDED = 3'h4;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	typedef enum logic [2:0] {
		MODE_BASIC = 3'h0, MODE_ACCUMULATE = 3'h1, MODE_AVERAGE = 3'h2,
		MODE_BURST = 3'h3, MODE_LOWPASS = 3'h4
	} compute_mode_type;
	typedef enum logic [2:0] {
		ERR_RES_PREV = 3'h0, ERR_RES_SETPT = 3'h1, ERR_RES_FILT = 3'h2,
		ERR_PREV_FILT = 3'h4, ERR_FILT_SETPT = 3'h5
	} error_select_type;
	typedef struct packed {
		logic start;
		logic done;
		logic [11:0] data;
		logic [1:0] stage;
	} conv_in_type;
endpackage

// >>> adc_computation_threshold_unit.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - At conversion start, previous sample takes filter or latest result per select bit.
// R2 - Low-pass mode uses time constant two to the shift, unity gain.
// R3 - Accumulate and average modes right-shift accumulated value by shift select.
// R4 - Basic mode ignores shift select completely.
// R5 - Software never programs shift select to 111 or 000.
// R6 - Writing 1 to accumulator clear empties accumulator, counter, overflow flag.
// R7 - Accumulator clear bit drops by itself once clearing finishes.
// R8 - Mode field picks basic, accumulate, average, burst average or low-pass.
// R9 - Software sets repeat count to two to the shift for true averages.
// R10 - Error select picks which difference forms the error value.
// R11 - Double-sample error selects 001/010 subtract previous first.
// R12 - Double-sample with result as previous source computes error every second sample.
// R13 - Continuous with stop-on-threshold clears go when threshold condition hits.
// R14 - Continuous without stop-on-threshold never clears go; software must.
// R15 - Stop-on-threshold is ignored when continuous operation is off.
// R16 - Threshold mode field chooses the error comparison raising the interrupt.
// R17 - Overflow flag sets on accumulator, filter or error overflow; clearable.
// R18 - Above-upper flag reads 1 when error exceeds upper threshold.
// R19 - Below-lower flag reads 1 when error is under lower threshold.
// R20 - Update flag sets at each computation; not clearable while suspended.
// R21 - Stage status reports idle, first/second stages and suspended pair.
// R22 - Double-sampling pairs conversions, computing after each second one.
// R23 - Continuous mode retriggers go until threshold stop or software clear.
// R24 - Threshold flags update at each computation in the same cycle as the error.
// R25 - Writing 0 to accumulator clear has no effect.
module adc_computation_threshold_unit
	import adc_compute_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire conv_in_type i_conv,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_go,
	output logic o_threshold_irq
);
	logic [7:0] comp_ctrl;
	logic [7:0] err_ctrl;
	logic go, continuous_enable, double_sample_enable;
	logic accum_overflow_flag, above, below, upd;
	logic [15:0] uth, lth, stpt;
	logic [7:0] rpt;
	logic [ACC_W-1:0] acc;
	logic [7:0] cnt;
	logic [15:0] flt, prev, res, err;
	logic restart, second;
	logic wr_pend;
	logic [9:0] wr_idx;
	logic [2:0] stat;
	logic taken;
	logic [2:0] shift_select;
	logic ovf, hit, point;
	logic [ACC_W-1:0] next_acc;
	logic [15:0] next_flt, next_err;
	logic [7:0] next_cnt;
	logic next_restart;

	assign shift_select = comp_ctrl[SHIFT_LSB +: 3];
	assign taken = i_hsel & i_hready & i_htrans[1];
	// Zero-wait slave; every answer is OKAY
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_go = go;

	always_comb
	begin
		if (i_conv.stage != 2'h0)
			stat = {second, i_conv.stage}; // R21
		else if (second)
			stat = STAT_SUSPENDED; // R21
		else
			stat = STAT_IDLE;
	end

	// Bus address phase
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_pend <= 1'b0;
			wr_idx <= 10'h000;
			o_hrdata <= 32'h00000000;
		end
		else
		begin
			wr_pend <= taken & i_hwrite;
			wr_idx <= i_haddr[11:2];
			if (taken & !i_hwrite)
			begin
				case (i_haddr[11:2])
				IDX_RUN_CONTROL:
					o_hrdata <= {29'h0, double_sample_enable, continuous_enable, go};
				IDX_COMPUTE_CONTROL:
					o_hrdata <= {24'h0, comp_ctrl};
				IDX_ERROR_THRESHOLD_CONTROL:
					o_hrdata <= {24'h0, err_ctrl};
				IDX_COMPUTE_STATUS:
					o_hrdata <= {24'h0, accum_overflow_flag, above, below, upd, 1'b0, stat};
				IDX_THRESHOLDS:
					o_hrdata <= {uth, lth};
				IDX_SETPOINT_REPEAT:
					o_hrdata <= {8'h0, rpt, stpt};
				IDX_ACCUMULATOR:
					o_hrdata <= {14'h0, acc};
				IDX_FILTER_PREVIOUS:
					o_hrdata <= {flt, prev};
				IDX_ERROR_COUNT:
					o_hrdata <= {8'h0, cnt, err};
				default:
					o_hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Arithmetic for one finished conversion
	always_comb
	begin
		logic [ACC_W:0] sum;
		logic [ACC_W-1:0] base, shifted;
		logic [17:0] e, d;
		logic [15:0] r;
		sum = '0;
		e = '0;
		r = {4'h0, i_conv.data};
		d = {2'h0, r};
		shifted = '0;
		base = restart ? '0 : acc;
		case (comp_ctrl[MODE_LSB +: 3])
		MODE_LOWPASS:
			sum = {1'b0, acc} - {1'b0, acc >> shift_select}
				+ {3'h0, r}; // R2
		MODE_ACCUMULATE, MODE_AVERAGE, MODE_BURST:
			sum = {1'b0, base} + {3'h0, r};
		default:
			sum = {3'h0, r}; // R4
		endcase
		next_acc = sum[ACC_W-1:0];
		ovf = sum[ACC_W];
		if (comp_ctrl[MODE_LSB +: 3] == MODE_BASIC)
			shifted = next_acc; // R4
		else
			shifted = next_acc >> shift_select; // R3
		next_flt = shifted[15:0];
		ovf = ovf | (shifted[ACC_W-1:16] != 2'h0);
		next_cnt = (restart || cnt == COUNT_MAX) ?
			(restart ? 8'h01 : cnt) : cnt + 8'h01;
		next_restart = (comp_ctrl[MODE_LSB +: 3] == MODE_AVERAGE ||
			comp_ctrl[MODE_LSB +: 3] == MODE_BURST) &&
			next_cnt >= rpt;
		if (double_sample_enable)
			d = {2'h0, r} - {2'h0, prev}; // R11
		case (err_ctrl[ERR_SEL_LSB +: 3]) // R10
		ERR_RES_PREV:
			e = {2'h0, r} - {2'h0, prev};
		ERR_RES_SETPT:
			e = d - {{2{stpt[15]}}, stpt};
		ERR_RES_FILT:
			e = d - {2'h0, next_flt};
		ERR_PREV_FILT:
			e = {2'h0, prev} - {2'h0, next_flt};
		ERR_FILT_SETPT:
			e = {2'h0, next_flt} - {{2{stpt[15]}}, stpt};
		default:
			e = '0;
		endcase
		next_err = e[15:0];
		ovf = ovf | (e[17:15] != 3'h0 && e[17:15] != 3'h7); // R17
		case (err_ctrl[THR_MODE_LSB +: 3]) // R16
		3'h1: hit = $signed(next_err) < $signed(lth);
		3'h2: hit = $signed(next_err) >= $signed(lth);
		3'h3: hit = $signed(next_err) > $signed(lth) &&
			$signed(next_err) < $signed(uth);
		3'h4: hit = $signed(next_err) < $signed(lth) ||
			$signed(next_err) > $signed(uth);
		3'h5: hit = $signed(next_err) <= $signed(uth);
		3'h6: hit = $signed(next_err) > $signed(uth);
		3'h7: hit = 1'b1;
		default: hit = 1'b0;
		endcase
	end

	// Only the second conversion of a pair is a computation point
	assign point = i_conv.done & (!double_sample_enable | second); // R12 R22

	// Software configuration
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			err_ctrl <= ERROR_THRESHOLD_CONTROL_RESET;
			continuous_enable <= 1'b0;
			double_sample_enable <= 1'b0;
			uth <= 16'h0000;
			lth <= 16'h0000;
			stpt <= 16'h0000;
			rpt <= 8'h00;
		end
		else if (wr_pend)
		begin
			case (wr_idx)
			IDX_ERROR_THRESHOLD_CONTROL:
				err_ctrl <= {1'b0, i_hwdata[6:0]};
			IDX_RUN_CONTROL:
			begin
				continuous_enable <= i_hwdata[CONTINUOUS_ENABLE_BIT];
				double_sample_enable <= i_hwdata[DOUBLE_SAMPLE_ENABLE_BIT];
			end
			IDX_THRESHOLDS:
			begin
				uth <= i_hwdata[31:16];
				lth <= i_hwdata[15:0];
			end
			IDX_SETPOINT_REPEAT:
			begin
				stpt <= i_hwdata[15:0];
				rpt <= i_hwdata[23:16];
			end
			default: ;
			endcase
		end
	end

	// Mode, shift and clear command; clear runs in the cycle after it is set
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			comp_ctrl <= COMPUTE_CONTROL_RESET;
		else if (wr_pend && wr_idx == IDX_COMPUTE_CONTROL)
			comp_ctrl <= {i_hwdata[7:4],
				comp_ctrl[ACCUM_CLEAR_BIT] | i_hwdata[3],
				i_hwdata[2:0]}; // R6 R25
		else if (comp_ctrl[ACCUM_CLEAR_BIT])
			comp_ctrl[ACCUM_CLEAR_BIT] <= 1'b0; // R7
	end

	// Accumulator and counter
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			acc <= '0;
			cnt <= 8'h00;
			restart <= 1'b0;
			flt <= 16'h0000;
			err <= 16'h0000;
		end
		else if (comp_ctrl[ACCUM_CLEAR_BIT])
		begin
			acc <= '0; // R6
			cnt <= 8'h00;
			restart <= 1'b0;
		end
		else if (point)
		begin
			acc <= next_acc; // R8
			cnt <= next_cnt;
			restart <= next_restart;
			flt <= next_flt;
			err <= next_err;
		end
	end

	// Result and previous sample
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			res <= 16'h0000;
			prev <= 16'h0000;
			second <= 1'b0;
		end
		else
		begin
			if (i_conv.done)
				res <= {4'h0, i_conv.data};
			if (i_conv.start)
				prev <= comp_ctrl[PREV_SRC_BIT] ? flt : res; // R1
			if (!double_sample_enable)
				second <= 1'b0;
			else if (i_conv.done)
				second <= !second; // R22
		end
	end

	// Status flags; hardware set wins over software clear
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			accum_overflow_flag <= 1'b0;
			above <= 1'b0;
			below <= 1'b0;
			upd <= 1'b0;
		end
		else
		begin
			if (point & !comp_ctrl[ACCUM_CLEAR_BIT] & ovf)
				accum_overflow_flag <= 1'b1; // R17
			else if (comp_ctrl[ACCUM_CLEAR_BIT])
				accum_overflow_flag <= 1'b0; // R6
			else if (wr_pend && wr_idx == IDX_COMPUTE_STATUS &&
				!i_hwdata[OVERFLOW_BIT])
				accum_overflow_flag <= 1'b0;
			// Flags follow the error value, which a clear cycle holds
			if (point & !comp_ctrl[ACCUM_CLEAR_BIT])
			begin
				above <= $signed(next_err) > $signed(uth); // R18 R24
				below <= $signed(next_err) < $signed(lth); // R19 R24
			end
			if (point | (i_conv.done & double_sample_enable))
				upd <= 1'b1; // R20
			else if (wr_pend && wr_idx == IDX_COMPUTE_STATUS &&
				!i_hwdata[UPDATE_BIT] && stat != STAT_SUSPENDED)
				upd <= 1'b0; // R20
		end
	end

	// Go bit and threshold interrupt pulse
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			go <= 1'b0;
			o_threshold_irq <= 1'b0;
		end
		else
		begin
			o_threshold_irq <= point & hit;
			// A software write in the same cycle overrides hardware
			if (wr_pend && wr_idx == IDX_RUN_CONTROL)
				go <= i_hwdata[GO_BIT]; // R14
			else if (i_conv.done & !continuous_enable)
				go <= 1'b0; // R15
			else if (point & hit & continuous_enable & err_ctrl[STOP_ON_THR_BIT])
				go <= 1'b0; // R13 R23
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic go_wr;
	assign go_wr = wr_pend && wr_idx == IDX_RUN_CONTROL;

	a_prev_copy: assert property (i_conv.start |=> // R1
		prev == ($past(comp_ctrl[PREV_SRC_BIT]) ? $past(flt) : $past(res)))
		else $error("previous sample source wrong");
	a_clear_done: assert property ( // R6
		$rose(comp_ctrl[ACCUM_CLEAR_BIT]) |=>
		!comp_ctrl[ACCUM_CLEAR_BIT] && acc == '0 && cnt == 8'h00 && !accum_overflow_flag)
		else $error("accumulator clear incomplete");
	a_basic_noshift: assert property ( // R4
		point && comp_ctrl[2:0] == MODE_BASIC &&
		!comp_ctrl[ACCUM_CLEAR_BIT] |=> flt == res)
		else $error("basic mode applied shift");
	a_accum_shift: assert property ( // R3
		point && comp_ctrl[2:0] == MODE_ACCUMULATE &&
		!comp_ctrl[ACCUM_CLEAR_BIT] |=>
		flt == 16'(acc >> $past(shift_select)))
		else $error("accumulate shift wrong");
	a_upper_flag: assert property ( // R18
		point && !comp_ctrl[ACCUM_CLEAR_BIT] |=>
		above == ($signed(err) > $signed(uth)))
		else $error("upper flag mismatch");
	a_lower_flag: assert property ( // R19
		point && !comp_ctrl[ACCUM_CLEAR_BIT] |=>
		below == ($signed(err) < $signed(lth)))
		else $error("lower flag mismatch");
	a_soi_stop: assert property ( // R13
		point && hit && continuous_enable && err_ctrl[STOP_ON_THR_BIT] && !go_wr
		|=> !o_go && o_threshold_irq)
		else $error("go not stopped on threshold");
	a_continuous_enable_keep: assert property ( // R14
		o_go && continuous_enable && !err_ctrl[STOP_ON_THR_BIT] && !go_wr |=> o_go)
		else $error("go cleared by hardware");
	a_single_stop: assert property (i_conv.done && !continuous_enable && !go_wr // R15
		|=> !o_go)
		else $error("go kept without continuous mode");
	a_pair_point: assert property ( // R22
		double_sample_enable && i_conv.done && !second |=> !o_threshold_irq)
		else $error("computed on first of pair");
	a_suspend_stat: assert property ( // R21
		second && i_conv.stage == 2'h0 |-> stat == STAT_SUSPENDED)
		else $error("suspended status missing");
	a_update_hold: assert property ( // R20
		stat == STAT_SUSPENDED && upd |=> upd)
		else $error("update flag cleared while suspended");
	c_irq: cover property (o_threshold_irq);
	c_pair: cover property (double_sample_enable && point);
	c_clear: cover property ($fell(comp_ctrl[ACCUM_CLEAR_BIT]));
	c_soi: cover property (continuous_enable && $fell(o_go));
endmodule

// >>> conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model
	import adc_compute_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_go,
	input wire logic i_slow,
	input wire logic [11:0] i_sample,
	output conv_in_type o_conv
);
	logic st;
	logic dn;
	logic [1:0] stage;
	logic [2:0] cnt;
	logic [1:0] gap;
	logic [11:0] held;
	logic [2:0] len;
	assign len = i_slow ? 3'h4 : 3'h0;
	// Outside the done pulse the data lines carry junk, never the result
	assign o_conv = {st, dn, dn ? held : ~held, stage};
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st <= 1'b0;
			dn <= 1'b0;
			stage <= 2'h0;
			cnt <= 3'h0;
			gap <= 2'h0;
			held <= 12'h000;
		end
		else
		begin
			st <= 1'b0;
			dn <= 1'b0;
			if (stage == 2'h0)
			begin
				// Idle gap lets the go bit settle after a result
				if (gap != 2'h0)
					gap <= gap - 2'h1;
				else if (i_go)
				begin
					st <= 1'b1;
					stage <= 2'h1;
					cnt <= len;
				end
			end
			else if (!i_go)
				stage <= 2'h0;
			else if (cnt != 3'h0)
				cnt <= cnt - 3'h1;
			else if (stage == 2'h3)
			begin
				dn <= 1'b1;
				held <= i_sample;
				stage <= 2'h0;
				gap <= 2'h3;
			end
			else
			begin
				stage <= stage + 2'h1;
				cnt <= len;
			end
		end
	end
endmodule

// >>> adc_computation_threshold_unit_bench.sv
`timescale 1ns/1ps
module adc_computation_threshold_unit_bench
	import adc_compute_pkg::*;
;
	localparam logic [9:0] RUN = IDX_RUN_CONTROL;
	localparam logic [9:0] CCR = IDX_COMPUTE_CONTROL;
	localparam logic [9:0] ETC = IDX_ERROR_THRESHOLD_CONTROL;
	localparam logic [9:0] STS = IDX_COMPUTE_STATUS;
	localparam logic [9:0] FPR = IDX_FILTER_PREVIOUS;
	localparam logic [9:0] ECR = IDX_ERROR_COUNT;
	logic clk;
	logic rst_n;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic go;
	logic irq;
	logic slow;
	logic [11:0] sample;
	conv_in_type conv;
	int bad_count = 0;
	int n_checks = 0;
	int irq_n = 0;
	int done_n = 0;
	int m, k, e, d, p, ex, c;
	int sel[6] = '{0, 1, 2, 4, 5, 3};
	adc_computation_threshold_unit adc_computation_threshold_unit_inst (
		.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hreadyout), .i_conv(conv),
		.o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.o_go(go), .o_threshold_irq(irq));
	conv_core_model conv_core_model_inst (.i_clk(clk), .i_rst_n(rst_n),
		.i_go(go), .i_slow(slow), .i_sample(sample), .o_conv(conv));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (irq === 1'b1)
			irq_n++;
		if (conv.done === 1'b1)
			done_n++;
	end
	task stop_test;
		$display("checks %0d bad %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
		n_checks++;
		if (seen !== x)
		begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, x, seen);
		end
	endtask
	task bus(input logic [9:0] idx, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {20'h0, idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task wr(input logic [9:0] idx, input logic [31:0] wd);
		logic [31:0] x;
		bus(idx, 1'b1, wd, x);
	endtask
	task rc(input string nm, input logic [9:0] idx, input logic [31:0] mk,
		input logic [31:0] x);
		logic [31:0] r;
		bus(idx, 1'b0, 32'h0, r);
		chk(nm, r & mk, x);
	endtask
	task run(input int v, input logic [31:0] ctl, input int n);
		int s;
		s = done_n;
		sample <= v[11:0];
		wr(RUN, ctl);
		wait (done_n >= s + n);
		repeat (4) @(posedge clk);
	endtask
	function automatic int want(input int md, input int er);
		case (md)
			0: return 0;
			1: return er < -100;
			2: return er >= -100;
			3: return er > -100 && er < 100;
			4: return er < -100 || er > 100;
			5: return er <= 100;
			6: return er > 100;
			default: return 1;
		endcase
	endfunction
	initial
	begin
		repeat (60000) @(posedge clk);
		bad_count++;
		stop_test;
	end
	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		slow = 1'b0;
		sample = 12'h000;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rc("cc_rst", CCR, 32'hff, 32'h00);
		rc("etc_rst", ETC, 32'hff, 32'h00);
		rc("sts_rst", STS, 32'hff, 32'h00);
		rc("unmapped", 10'h100, 32'hffffffff, 32'h0);
		chk("resp", {hreadyout, hresp}, 32'h2);
		wr(CCR, 32'hbb);
		rc("cc_rw", CCR, 32'hff, 32'hb3);
		wr(ETC, 32'hff);
		rc("etc_rw", ETC, 32'hff, 32'h7f);
		wr(IDX_THRESHOLDS, 32'h0064ff9c);
		wr(IDX_SETPOINT_REPEAT, 32'd1000);
		wr(CCR, 32'h60);
		for (m = 0; m < 8; m++)
			for (k = 0; k < 3; k++)
			begin
				e = 200 * k - 200;
				wr(ETC, 32'h10 | m);
				c = irq_n;
				run(1000 + e, 32'h1, 1);
				chk("irq", irq_n - c, want(m, e));
				rc("err", ECR, 32'hffff, e[15:0]);
				rc("flags", STS, 32'hff, {1'b0, e > 100, e < -100, 5'h10});
				rc("flt", FPR, 32'hffff0000, (1000 + e) << 16);
			end
		p = 1200;
		for (k = 0; k < 6; k++)
		begin
			d = 400 + 100 * k;
			case (sel[k])
				0: ex = d - p;
				1, 5: ex = d - 1000;
				4: ex = p - d;
				default: ex = 0;
			endcase
			wr(ETC, sel[k] << 4);
			run(d, 32'h1, 1);
			rc("esel", ECR, 32'hffff, ex[15:0]);
			rc("prev", FPR, 32'hffff, p);
			p = d;
		end
		wr(CCR, 32'ha9);
		wr(ETC, 32'h0);
		run(300, 32'h1, 1);
		run(500, 32'h1, 1);
		rc("acc", IDX_ACCUMULATOR, 32'h3ffff, 32'd800);
		rc("flt_prev", FPR, 32'hffffffff, {16'd200, 16'd75});
		rc("err_cnt", ECR, 32'hffffff, {8'd2, 16'd425});
		wr(IDX_SETPOINT_REPEAT, 32'h8000);
		wr(ETC, 32'h10);
		run(4095, 32'h1, 1);
		rc("ovf", STS, 32'h80, 32'h80);
		wr(CCR, 32'ha9);
		rc("acc_clr", IDX_ACCUMULATOR, 32'h3ffff, 32'h0);
		rc("cnt_clr", ECR, 32'hff0000, 32'h0);
		rc("ovf_clr", STS, 32'h80, 32'h0);
		run(4095, 32'h1, 1);
		wr(STS, 32'h7f);
		rc("ovf_sw", STS, 32'h90, 32'h10);
		wr(IDX_SETPOINT_REPEAT, 32'h00020000);
		wr(CCR, 32'h1a);
		run(600, 32'h1, 1);
		run(800, 32'h1, 1);
		rc("avg", FPR, 32'hffff0000, 32'd700 << 16);
		// Target count reached, so the next sample starts a new sum
		run(200, 32'h1, 1);
		rc("avg_new", FPR, 32'hffff0000, 32'd100 << 16);
		rc("cnt_new", ECR, 32'hff0000, 32'h10000);
		wr(CCR, 32'h1b);
		run(600, 32'h1, 1);
		run(800, 32'h1, 1);
		rc("burst", FPR, 32'hffff0000, 32'd700 << 16);
		wr(CCR, 32'h1c);
		run(1000, 32'h1, 1);
		rc("lp1", FPR, 32'hffff0000, 32'd500 << 16);
		run(1000, 32'h1, 1);
		rc("lp2", FPR, 32'hffff0000, 32'd750 << 16);
		// Slow partner from here on so go changes land mid-conversion
		slow <= 1'b1;
		wr(ETC, 32'h0f);
		c = done_n;
		run(1, 32'h3, 1);
		repeat (40) @(posedge clk);
		chk("go_soi", go, 1'b0);
		chk("runs_soi", done_n - c, 1);
		wr(ETC, 32'h08);
		run(1, 32'h3, 3);
		chk("go_miss", go, 1'b1);
		wr(RUN, 32'h0);
		@(posedge clk);
		chk("go_sw", go, 1'b0);
		wr(ETC, 32'h07);
		run(1, 32'h3, 3);
		chk("go_continuous_enable", go, 1'b1);
		wr(RUN, 32'h0);
		@(posedge clk);
		chk("go_stop", go, 1'b0);
		wr(ETC, 32'h08);
		c = done_n;
		run(1, 32'h1, 1);
		repeat (40) @(posedge clk);
		chk("go_single", go, 1'b0);
		chk("runs_single", done_n - c, 1);
		wr(IDX_SETPOINT_REPEAT, 32'd1000);
		wr(ETC, 32'h17);
		wr(CCR, 32'h60);
		c = irq_n;
		run(1500, 32'h5, 1);
		rc("ds_sts", STS, 32'h17, 32'h14);
		chk("ds_irq1", irq_n - c, 0);
		wr(STS, 32'h0);
		rc("ds_upd", STS, 32'h10, 32'h10);
		run(1700, 32'h5, 1);
		rc("ds_err", ECR, 32'hffff, 32'hfce0);
		chk("ds_irq2", irq_n - c, 1);
		rc("ds_idle", STS, 32'h17, 32'h10);
		wr(STS, 32'h0);
		rc("upd_clr", STS, 32'h10, 32'h0);
		stop_test;
	end
endmodule
